// File: rtl/tcu_pin_if.sv
// interface between the pin sampler and the timer core
`timescale 1ns/1ps
`default_nettype none
interface tcu_pin_if;
    logic sample_stb;
    logic [3:0] fall;
    modport sampler (input sample_stb, output fall);
    modport core (output sample_stb, input fall);
endinterface
`default_nettype wire

// File: rtl/tcu_pin_sampler.sv
// samples the count and trigger pins once per machine cycle
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_sampler
    import tcu_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] pins,
    tcu_pin_if.sampler pif
);
    logic [3:0] smp_ff;
    logic [3:0] fall_ff;

    ////////////////////////////////////////////////////////////////////////
    // one sample per machine cycle; an edge needs a high sample then a low
    // one, so detection spans two machine cycles and limits the rate
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            smp_ff <= 4'hF;
            fall_ff <= 4'h0;
        end else begin
            if (pif.sample_stb) begin
                smp_ff <= pins;
            end
            fall_ff <= pif.sample_stb ? (smp_ff & ~pins) : 4'h0;
        end
    end

    assign pif.fall = fall_ff;
endmodule // tcu_pin_sampler
`default_nettype wire

// File: rtl/tcu_pkg.sv
// constants and types shared by the timer/counter unit
// How it works
// - mode 0 is 8-bit count behind a divide-by-32 prescaler; mode 1 is 16-bit.
// - mode 2 counts the low byte and reloads it from the high byte on overflow.
// - mode 3 splits timer 0 into two 8-bit counters; timer 1 holds still.
// - timer function counts once per machine cycle, oscillator divided by 12.
// - counter function counts each falling edge sampled on the count pin.
// - edge detection takes two machine cycles, so sources stay below osc/24.
// - gate option makes counting also wait for the matching gate pin high.
// - timer 2 is 16-bit up/down; source select picks cycles or count pin.
// - auto-reload from reload register on overflow, and on trigger edge if enabled.
// - with up/down enabled the trigger level sets direction; trigger enable ignored.
// - capture mode counts up; enabled trigger edge copies count into reload register.
// - baud select runs timer 2 at osc/2, no overflow flag; trigger edge flags.
// - baud rate equals osc over 32 times (65536 minus reload value).
// - mode register holds gate, source select and 2-bit mode per timer.
// - control bits from bit 7: overflow 1, run 1, overflow 0, run 0.
// - timer 2 control layout bit 7..0; up/down enable sits apart.
package tcu_pkg;
    localparam int MC_DIV = 12;
    localparam logic [3:0] MC_LAST = 4'hB;
    localparam logic [7:0] MODE_REG_RESET = 8'h00;
    localparam int GATE_BIT = 3;
    localparam int SRC_BIT = 2;
    localparam int PRESCALE_BITS = 5;
    localparam int FLG_OVF0 = 0;
    localparam int FLG_OVF1 = 1;
    localparam int FLG_OVF2 = 2;
    localparam int FLG_TRIG2 = 3;
    localparam int PIN_ZERO = 0;
    localparam int PIN_ONE = 1;
    localparam int PIN_THIRD = 2;
    localparam int PIN_TRIG = 3;
    localparam logic [15:0] WIDE_ONES = 16'hFFFF;

    typedef enum logic [1:0] {
        TCU_MODE_PRESCALE = 2'h0,
        TCU_MODE_WIDE = 2'h1,
        TCU_MODE_RELOAD = 2'h2,
        TCU_MODE_SPLIT = 2'h3
    } tcu_mode_t;

    typedef enum logic [2:0] {
        TCU_WS_LO0 = 3'h0,
        TCU_WS_HI0 = 3'h1,
        TCU_WS_LO1 = 3'h2,
        TCU_WS_HI1 = 3'h3,
        TCU_WS_LO2 = 3'h4,
        TCU_WS_HI2 = 3'h5,
        TCU_WS_RCL = 3'h6,
        TCU_WS_RCH = 3'h7
    } tcu_wsel_t;
endpackage

// File: rtl/tcu_timer_unit.sv
// timer/counter unit: timers 0 and 1 plus the 16-bit timer 2
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_unit
    import tcu_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] timer01_mode_reg,
    input wire logic timer_zero_run,
    input wire logic timer_one_run,
    input wire logic third_timer_run,
    input wire logic third_timer_source_select,
    input wire logic capture_reload_select,
    input wire logic trigger_pin_enable,
    input wire logic receive_baud_select,
    input wire logic transmit_baud_select,
    input wire logic updown_enable,
    input wire logic timer_zero_count_pin,
    input wire logic timer_one_count_pin,
    input wire logic third_timer_count_pin,
    input wire logic third_timer_trigger_pin,
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    input wire logic wr_en,
    input wire logic [2:0] wr_sel,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] flag_clr,
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag,
    output logic third_timer_overflow_flag,
    output logic third_timer_trigger_flag,
    output logic [7:0] timer01_control_reg,
    output logic [7:0] third_timer_control_reg,
    output logic [7:0] timer_zero_low_byte,
    output logic [7:0] timer_zero_high_byte,
    output logic [7:0] timer_one_low_byte,
    output logic [7:0] timer_one_high_byte,
    output logic [7:0] third_count_low,
    output logic [7:0] third_count_high,
    output logic [7:0] reload_capture_low,
    output logic [7:0] reload_capture_high,
    output logic timer_one_ovf_pulse,
    output logic third_timer_baud_pulse
);
    tcu_pin_if pif ();

    logic [3:0] mc_cnt_ff;
    logic [7:0] lo0_ff, hi0_ff, lo1_ff, hi1_ff, lo2_ff, hi2_ff, rcl_ff, rch_ff;
    logic [3:0] flag_ff;
    logic ovf1_pulse_ff, baud_pulse_ff;
    logic [7:0] nxt_lo0, nxt_hi0, nxt_lo1, nxt_hi1, nxt_lo2, nxt_hi2, nxt_rcl, nxt_rch;
    logic [3:0] nxt_flag;

    // one step of a timer 0/1 pair: {overflow, high, low}
    function automatic logic [16:0] tcu_step(input logic [1:0] mode, input logic [7:0] hi,
                                             input logic [7:0] lo);
        logic [12:0] s13;
        logic [15:0] s16;
        logic [16:0] r;
        s13 = {hi, lo[PRESCALE_BITS-1:0]} + 13'h1;
        s16 = {hi, lo} + 16'h1;
        case (mode)
            TCU_MODE_PRESCALE: r = {&{hi, lo[PRESCALE_BITS-1:0]}, s13[12:5], lo[7:5],
                                    s13[4:0]};
            TCU_MODE_WIDE: r = {&{hi, lo}, s16};
            TCU_MODE_RELOAD: r = {&lo, hi, (&lo) ? hi : lo + 8'h01};
            TCU_MODE_SPLIT: r = {&lo, hi, lo + 8'h01};
            default: r = {1'b0, hi, lo};
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // machine cycle divider
    wire mc_tick = (mc_cnt_ff == MC_LAST);
    wire half_tick = mc_cnt_ff[0]; // every second clock for baud mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mc_cnt_ff <= 4'h0;
        end else begin
            mc_cnt_ff <= mc_tick ? 4'h0 : mc_cnt_ff + 4'h1;
        end
    end

    assign pif.sample_stb = mc_tick;
    tcu_pin_sampler u_sampler (
        .mclk(mclk),
        .rstn(rstn),
        .pins({third_timer_trigger_pin, third_timer_count_pin, timer_one_count_pin,
               timer_zero_count_pin}),
        .pif(pif)
    );

    ////////////////////////////////////////////////////////////////////////
    // timers 0 and 1: count enables, steps and overflow events
    wire [1:0] mode0 = timer01_mode_reg[1:0];
    wire [1:0] mode1 = timer01_mode_reg[5:4];
    wire gate0 = timer01_mode_reg[GATE_BIT];
    wire gate1 = timer01_mode_reg[GATE_BIT+4];
    wire src0 = timer01_mode_reg[SRC_BIT];
    wire src1 = timer01_mode_reg[SRC_BIT+4];
    wire split0 = (mode0 == TCU_MODE_SPLIT);
    wire inc0 = timer_zero_run & (~gate0 | gate_pin_zero)
                & (src0 ? pif.fall[PIN_ZERO] : mc_tick);
    wire inc0h = split0 & timer_one_run & mc_tick;
    wire inc1 = timer_one_run & (~gate1 | gate_pin_one) & (mode1 != TCU_MODE_SPLIT)
                & (src1 ? pif.fall[PIN_ONE] : mc_tick);
    wire [16:0] step0 = tcu_step(mode0, hi0_ff, lo0_ff);
    wire [16:0] step1 = tcu_step(mode1, hi1_ff, lo1_ff);
    wire ovf0 = inc0 & step0[16];
    wire ovf0h = inc0h & (&hi0_ff);
    wire ovf1 = inc1 & step1[16];
    wire wr_lo0 = wr_en & (wr_sel == TCU_WS_LO0);
    wire wr_hi0 = wr_en & (wr_sel == TCU_WS_HI0);
    wire wr_lo1 = wr_en & (wr_sel == TCU_WS_LO1);
    wire wr_hi1 = wr_en & (wr_sel == TCU_WS_HI1);
    wire wr_lo2 = wr_en & (wr_sel == TCU_WS_LO2);
    wire wr_hi2 = wr_en & (wr_sel == TCU_WS_HI2);

    // a software write to a count byte wins over the count in that cycle
    assign nxt_lo0 = wr_lo0 ? wr_data : (inc0 ? step0[7:0] : lo0_ff);
    assign nxt_hi0 = wr_hi0 ? wr_data
                   : (split0 ? (inc0h ? hi0_ff + 8'h01 : hi0_ff)
                   : (inc0 ? step0[15:8] : hi0_ff));
    assign nxt_lo1 = wr_lo1 ? wr_data : (inc1 ? step1[7:0] : lo1_ff);
    assign nxt_hi1 = wr_hi1 ? wr_data : (inc1 ? step1[15:8] : hi1_ff);

    ////////////////////////////////////////////////////////////////////////
    // timer 2: source, mode decode and next state
    wire baud_mode = receive_baud_select | transmit_baud_select;
    wire [15:0] cnt2 = {hi2_ff, lo2_ff};
    wire [15:0] rc2 = {rch_ff, rcl_ff};
    wire trig_fall = pif.fall[PIN_TRIG];
    wire tick2 = third_timer_source_select ? pif.fall[PIN_THIRD]
               : (baud_mode ? half_tick : mc_tick);
    wire inc2 = third_timer_run & tick2;
    wire updown = ~baud_mode & ~capture_reload_select & updown_enable;
    wire count_down = updown & ~third_timer_trigger_pin;
    wire ovf2 = inc2 & (count_down ? (cnt2 == rc2) : (cnt2 == WIDE_ONES));
    wire trig_evt = third_timer_run & trigger_pin_enable & trig_fall & ~updown;
    wire capture_evt = trig_evt & ~baud_mode & capture_reload_select;
    wire reload_evt = trig_evt & ~baud_mode & ~capture_reload_select;

    logic [15:0] cnt2_nxt;
    always_comb begin
        cnt2_nxt = cnt2;
        if (reload_evt) begin
            cnt2_nxt = rc2;
        end else if (inc2) begin
            if (ovf2 && count_down) begin
                cnt2_nxt = WIDE_ONES;
            end else if (ovf2 && (!capture_reload_select || baud_mode)) begin
                // baud mode reloads whatever the capture/reload select says
                cnt2_nxt = rc2;
            end else begin
                cnt2_nxt = count_down ? cnt2 - 16'h1 : cnt2 + 16'h1;
            end
        end
    end

    assign nxt_lo2 = wr_lo2 ? wr_data : cnt2_nxt[7:0];
    assign nxt_hi2 = wr_hi2 ? wr_data : cnt2_nxt[15:8];
    assign nxt_rcl = (wr_en && wr_sel == TCU_WS_RCL) ? wr_data
                   : (capture_evt ? lo2_ff : rcl_ff);
    assign nxt_rch = (wr_en && wr_sel == TCU_WS_RCH) ? wr_data
                   : (capture_evt ? hi2_ff : rch_ff);

    // flags: a set in the same cycle as a clear wins
    wire [3:0] flag_set;
    assign flag_set[FLG_OVF0] = ovf0;
    assign flag_set[FLG_OVF1] = split0 ? ovf0h : ovf1;
    assign flag_set[FLG_OVF2] = ovf2 & ~baud_mode;
    assign flag_set[FLG_TRIG2] = trig_evt;
    assign nxt_flag = flag_set | (flag_ff & ~flag_clr);

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {lo0_ff, hi0_ff, lo1_ff, hi1_ff} <= 32'h0000_0000;
            {lo2_ff, hi2_ff, rcl_ff, rch_ff} <= 32'h0000_0000;
            flag_ff <= 4'h0;
            ovf1_pulse_ff <= 1'b0;
            baud_pulse_ff <= 1'b0;
        end else begin
            {lo0_ff, hi0_ff, lo1_ff, hi1_ff} <= {nxt_lo0, nxt_hi0, nxt_lo1, nxt_hi1};
            {lo2_ff, hi2_ff, rcl_ff, rch_ff} <= {nxt_lo2, nxt_hi2, nxt_rcl, nxt_rch};
            flag_ff <= nxt_flag;
            ovf1_pulse_ff <= ovf1;
            baud_pulse_ff <= ovf2 & baud_mode;
        end
    end

    // status views
    assign timer_zero_overflow_flag = flag_ff[FLG_OVF0];
    assign timer_one_overflow_flag = flag_ff[FLG_OVF1];
    assign third_timer_overflow_flag = flag_ff[FLG_OVF2];
    assign third_timer_trigger_flag = flag_ff[FLG_TRIG2];
    assign timer01_control_reg = {flag_ff[FLG_OVF1], timer_one_run, flag_ff[FLG_OVF0],
                                  timer_zero_run, 4'h0};
    assign third_timer_control_reg = {flag_ff[FLG_OVF2], flag_ff[FLG_TRIG2],
                                      receive_baud_select, transmit_baud_select,
                                      trigger_pin_enable, third_timer_run,
                                      third_timer_source_select,
                                      capture_reload_select};
    assign {timer_zero_low_byte, timer_zero_high_byte} = {lo0_ff, hi0_ff};
    assign {timer_one_low_byte, timer_one_high_byte} = {lo1_ff, hi1_ff};
    assign {third_count_low, third_count_high} = {lo2_ff, hi2_ff};
    assign {reload_capture_low, reload_capture_high} = {rcl_ff, rch_ff};
    assign timer_one_ovf_pulse = ovf1_pulse_ff;
    assign third_timer_baud_pulse = baud_pulse_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_mc_spacing;
        @(posedge mclk) disable iff (!rstn) mc_tick |=> !mc_tick [*8];
    endproperty
    a_mc_spacing: assert property (p_mc_spacing) else $error("machine tick too soon");

    property p_fall_on_sample;
        @(posedge mclk) disable iff (!rstn) (|pif.fall) |-> $past(mc_tick);
    endproperty
    a_fall_on_sample: assert property (p_fall_on_sample) else $error("edge off sample");

    property p_mode2_reload;
        @(posedge mclk) disable iff (!rstn)
            (mode0 == TCU_MODE_RELOAD && ovf0 && !wr_en) |=> (lo0_ff == $past(hi0_ff));
    endproperty
    a_mode2_reload: assert property (p_mode2_reload) else $error("no mode 2 reload");

    property p_timer1_split_hold;
        @(posedge mclk) disable iff (!rstn)
            (mode1 == TCU_MODE_SPLIT && !wr_en) |=> $stable({lo1_ff, hi1_ff});
    endproperty
    a_timer1_split_hold: assert property (p_timer1_split_hold) else $error("timer 1 moved");

    property p_gate_blocks;
        @(posedge mclk) disable iff (!rstn)
            (gate0 && !gate_pin_zero && !wr_en) |=> $stable(lo0_ff);
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer 0 counted");

    property p_third_stop;
        @(posedge mclk) disable iff (!rstn)
            (!third_timer_run && !wr_en) |=> $stable({hi2_ff, lo2_ff, rch_ff, rcl_ff});
    endproperty
    a_third_stop: assert property (p_third_stop) else $error("timer 2 moved while off");

    property p_capture;
        @(posedge mclk) disable iff (!rstn)
            (capture_evt && !wr_en) |=> ({rch_ff, rcl_ff} == $past(cnt2)) && third_timer_trigger_flag;
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost");

    property p_baud_no_flag;
        @(posedge mclk) disable iff (!rstn)
            (baud_mode && !third_timer_overflow_flag) |=> !third_timer_overflow_flag;
    endproperty
    a_baud_no_flag: assert property (p_baud_no_flag) else $error("baud mode set flag");

    property p_set_wins;
        @(posedge mclk) disable iff (!rstn)
            (ovf0 && flag_clr[FLG_OVF0]) |=> timer_zero_overflow_flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("overflow lost to clear");
endmodule // tcu_timer_unit
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the timer/counter unit
`timescale 1ns/1ps
`default_nettype none
module tb import tcu_pkg::*; ;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] mode_reg = 8'h00;
    logic run0 = 1'b0, run1 = 1'b0, run2 = 1'b0, src2 = 1'b0, cap = 1'b0;
    logic trig_en = 1'b0, rx = 1'b0, tx = 1'b0, updown = 1'b0, wr_en = 1'b0;
    logic [2:0] wr_sel = 3'h0;
    logic [7:0] wr_data = 8'h00;
    logic [3:0] flag_clr = 4'h0;
    wire logic [5:0] pins;
    logic ovf0, ovf1, ovf2, trig, baud, p1;
    logic [7:0] ctl01, ctl2, lo0, hi0, lo1, hi1, lo2, hi2, rcl, rch;
    logic [5:0] ev;
    logic [15:0] held;
    int err_count = 0;
    int comparisons = 0;
    int n;

    ////////////////////////////////////////////////////////////////////////////////
    always #25 mclk = ~mclk;
    assign ev = {p1, ovf1, baud, trig, ovf2, ovf0};

    tcu_pin_model i_pins (.mclk(mclk), .pins(pins));

    tcu_timer_unit i_dut (.mclk(mclk), .rstn(rstn), .timer01_mode_reg(mode_reg),
        .timer_zero_run(run0), .timer_one_run(run1), .third_timer_run(run2),
        .third_timer_source_select(src2), .capture_reload_select(cap),
        .trigger_pin_enable(trig_en), .receive_baud_select(rx), .transmit_baud_select(tx),
        .updown_enable(updown), .timer_zero_count_pin(pins[0]), .timer_one_count_pin(pins[1]),
        .third_timer_count_pin(pins[2]), .third_timer_trigger_pin(pins[3]),
        .gate_pin_zero(pins[4]), .gate_pin_one(pins[5]), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .flag_clr(flag_clr), .timer_zero_overflow_flag(ovf0),
        .timer_one_overflow_flag(ovf1), .third_timer_overflow_flag(ovf2),
        .third_timer_trigger_flag(trig), .timer01_control_reg(ctl01),
        .third_timer_control_reg(ctl2), .timer_zero_low_byte(lo0), .timer_zero_high_byte(hi0),
        .timer_one_low_byte(lo1), .timer_one_high_byte(hi1), .third_count_low(lo2),
        .third_count_high(hi2), .reload_capture_low(rcl), .reload_capture_high(rch),
        .timer_one_ovf_pulse(p1), .third_timer_baud_pulse(baud));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // 16-bit values go in as two byte writes, low byte first
    task automatic wr16(input tcu_wsel_t lo_sel, input logic [15:0] v);
        @(posedge mclk);
        wr_en <= 1'b1;
        wr_sel <= lo_sel;
        wr_data <= v[7:0];
        @(posedge mclk);
        wr_sel <= lo_sel + 3'h1;
        wr_data <= v[15:8];
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic clr(input logic [3:0] m);
        @(posedge mclk);
        flag_clr <= m;
        @(posedge mclk);
        flag_clr <= 4'h0;
    endtask

    // bounded wait on one event bit, sampled where outputs have settled
    task automatic wait_ev(input int b);
        n = 0;
        while (ev[b] !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            $display("ERROR event %0d expected 1 seen timeout", b);
            report_and_stop();
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        chk("reset flags", 16'h0000, {10'h000, ev});
        // timer 0, 16-bit, machine-cycle source
        wr16(TCU_WS_LO0, 16'hFFFE);
        @(posedge mclk);
        mode_reg <= 8'h01;
        run0 <= 1'b1;
        wait_ev(0);
        chk("t0 wrap", 16'h0000, {hi0, lo0});
        chk("ctl01", 16'h0030, {8'h00, ctl01});
        n = 0;
        while (lo0 === 8'h00 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        chk("t0 rate", 16'(MC_DIV), 16'(n));
        clr(4'h1);
        @(negedge mclk);
        chk("ovf0 clear", 16'h0000, {15'h0000, ovf0});
        // mode 2 reloads the low byte, mode 0 keeps bits 7:5 of it
        run0 <= 1'b0;
        mode_reg <= 8'h02;
        wr16(TCU_WS_LO0, 16'h80FE);
        run0 <= 1'b1;
        wait_ev(0);
        chk("t0 reload", 16'h8080, {hi0, lo0});
        run0 <= 1'b0;
        mode_reg <= 8'h00;
        clr(4'h1);
        wr16(TCU_WS_LO0, 16'hFFFF);
        run0 <= 1'b1;
        wait_ev(0);
        chk("t0 prescale", 16'h00E0, {hi0, lo0});
        // gate option: low gate pin holds the count
        run0 <= 1'b0;
        mode_reg <= 8'h09;
        clr(4'h1);
        i_pins.level(4, 1'b0);
        wr16(TCU_WS_LO0, 16'hFFFF);
        run0 <= 1'b1;
        repeat (60) @(posedge mclk);
        chk("gate low", 16'hFFFF, {hi0, lo0});
        i_pins.level(4, 1'b1);
        wait_ev(0);
        chk("gate high", 16'h0000, {hi0, lo0});
        // timer 1 counts pin edges, then holds in mode 3
        run0 <= 1'b0;
        mode_reg <= 8'h59;
        run1 <= 1'b1;
        repeat (3) i_pins.fall(1);
        chk("t1 events", 16'h0003, {hi1, lo1});
        mode_reg <= 8'h39;
        repeat (60) @(posedge mclk);
        chk("t1 mode 3", 16'h0003, {hi1, lo1});
        // timer 1 in mode 2: reload and overflow pulse
        mode_reg <= 8'h21;
        wr16(TCU_WS_LO1, 16'hFEFE);
        wait_ev(5);
        chk("t1 reload", 16'hFEFE, {hi1, lo1});
        chk("ovf1", 16'h0001, {15'h0000, ovf1});
        // timer 2 capture on trigger edge, event counting
        run1 <= 1'b0;
        src2 <= 1'b1;
        cap <= 1'b1;
        trig_en <= 1'b1;
        run2 <= 1'b1;
        wr16(TCU_WS_LO2, 16'h1234);
        i_pins.fall(3);
        chk("capture", 16'h1234, {rch, rcl});
        chk("trig flag", 16'h0001, {15'h0000, trig});
        repeat (2) i_pins.fall(2);
        chk("t2 events", 16'h1236, {hi2, lo2});
        clr(4'h8);
        cap <= 1'b0;
        wr16(TCU_WS_RCL, 16'hAAAA);
        i_pins.fall(3);
        chk("trig reload", 16'hAAAA, {hi2, lo2});
        run2 <= 1'b0;
        src2 <= 1'b0;
        wr16(TCU_WS_LO2, 16'hFFFE);
        run2 <= 1'b1;
        wait_ev(1);
        chk("ovf reload", 16'hAAAA, {hi2, lo2});
        // down counting: trigger level low, its edge does nothing
        run2 <= 1'b0;
        updown <= 1'b1;
        wr16(TCU_WS_LO2, 16'h0002);
        wr16(TCU_WS_RCL, 16'h0000);
        clr(4'hC);
        run2 <= 1'b1;
        i_pins.level(3, 1'b0);
        wait_ev(1);
        chk("down wrap", 16'hFFFF, {hi2, lo2});
        chk("edge ignored", 16'h0000, {15'h0000, trig});
        i_pins.level(3, 1'b1);
        // baud: step every 2 clocks, 4 steps from FFFC
        run2 <= 1'b0;
        updown <= 1'b0;
        rx <= 1'b1;
        wr16(TCU_WS_LO2, 16'hFFFC);
        wr16(TCU_WS_RCL, 16'hFFFC);
        clr(4'hC);
        run2 <= 1'b1;
        wait_ev(3);
        @(negedge mclk);
        n = 1;
        while (baud !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        chk("baud period", 16'h0008, 16'(n));
        i_pins.fall(3);
        chk("baud flags", 16'h0001, {14'h0000, ovf2, trig});
        chk("ctl2", 16'h006C, {8'h00, ctl2});
        // run bit low freezes timer 2
        run2 <= 1'b0;
        @(negedge mclk);
        held = {hi2, lo2};
        repeat (40) @(posedge mclk);
        chk("t2 stopped", held, {hi2, lo2});
        report_and_stop();
    end
endmodule // tb
`default_nettype wire

// File: verification/tcu_pin_model.sv
// partner model of the external count, trigger and gate pins
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_model (
    input wire logic mclk,
    output var logic [5:0] pins
);
    // two machine cycles of 12 clocks each; levels under one machine cycle may be missed
    localparam int HOLD_CYC = 24;

    ////////////////////////////////////////////////////////////////////////////////
    // port lines idle high, as with their pull-ups
    initial begin
        pins = 6'h3F;
    end

    // one falling edge, each level held two machine cycles
    task automatic fall(input int idx);
        @(posedge mclk);
        pins[idx] <= 1'b0;
        repeat (HOLD_CYC) @(posedge mclk);
        pins[idx] <= 1'b1;
        repeat (HOLD_CYC) @(posedge mclk);
    endtask

    // new steady level from the next edge on; returns at once so that a
    // count enabled by it can be watched from its first step
    task automatic level(input int idx, input logic v);
        @(posedge mclk);
        pins[idx] <= v;
    endtask
endmodule // tcu_pin_model
`default_nettype wire
